// ---- hw/pec_edge_det.sv ----
// Synchronised per-pin rising and falling edge detector for one port
`timescale 1ns/10ps
module pec_edge_det import pec_pkg::*; #(
  parameter int WIDTH = 8,
  parameter logic [7:0] PIN_MASK = 8'hFF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins and enables
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] rise_en,
  input wire logic [WIDTH-1:0] fall_en,
  // Detected enabled edges
  output logic [WIDTH-1:0] edge_hit
);
  // Pin masks are byte wide, so refuse any other width at elaboration
  if (WIDTH != 8) begin : g_bad_width
    $error("pec_edge_det supports WIDTH 8 only");
  end
  logic [WIDTH-1:0] sync1_r, sync2_r, prev_r;
  logic [WIDTH-1:0] sync1_nxt, sync2_nxt, prev_nxt;

  // Two stage synchroniser then previous sample
  always_comb begin
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Both detectors per implemented pin, each gated by its own enable; pins outside PIN_MASK are tied low
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    if (PIN_MASK[i]) begin : g_on
      assign edge_hit[i] = (rise_en[i] & sync2_r[i] & ~prev_r[i])
                         | (fall_en[i] & ~sync2_r[i] & prev_r[i]);
    end else begin : g_off
      assign edge_hit[i] = 1'b0;
    end
  end
endmodule

// ---- hw/pec_pkg.sv ----
// Package for the pin edge-change interrupt unit: register map and field layouts
package pec_pkg;
  localparam int PEC_AW = 4;
  localparam int PEC_DW = 8;
  // Register offsets (chosen map)
  localparam logic [3:0] PEC_OFF_P1_RISE = 4'h0;
  localparam logic [3:0] PEC_OFF_P1_FALL = 4'h1;
  localparam logic [3:0] PEC_OFF_P1_FLAG = 4'h2;
  localparam logic [3:0] PEC_OFF_P2_RISE = 4'h3;
  localparam logic [3:0] PEC_OFF_P2_FALL = 4'h4;
  localparam logic [3:0] PEC_OFF_P2_FLAG = 4'h5;
  localparam logic [3:0] PEC_OFF_CTRL = 4'h6;
  localparam logic [3:0] PEC_OFF_EVT_STAT = 4'h7;
  localparam logic [3:0] PEC_OFF_EVT_MASK = 4'h8;
  // Implemented pin masks of each port
  localparam logic [7:0] PEC_P1_MASK = 8'h3F;
  localparam logic [7:0] PEC_P2_MASK = 8'hF0;
  // Control register fields
  localparam int PEC_CTRL_MIE_BIT = 0;
  localparam int PEC_CTRL_SUM_BIT = 1;
  localparam int PEC_CTRL_SLEEP_BIT = 2;
  // Event status fields: edge seen, wake issued
  localparam int PEC_EVT_EDGE_BIT = 0;
  localparam int PEC_EVT_WAKE_BIT = 1;
  localparam logic [1:0] PEC_EVT_W = 2'h3;
  localparam logic [7:0] PEC_RST_VAL = 8'h00;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pec_bus_req_t;

  // Per-port enable and flag set
  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flag;
  } pec_port_regs_t;
endpackage

// ---- hw/pec_top.sv ----
// Pin edge-change interrupt unit for two general-purpose ports
`timescale 1ns/10ps
module pec_top import pec_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Port pins
  input wire logic [7:0] first_gp_port,
  input wire logic [7:0] second_gp_port,
  // Core sleep state
  input wire logic core_sleep,
  // Requests
  output logic change_irq,
  output logic wake_req,
  output logic evt_irq
);
  pec_bus_req_t bus;
  pec_port_regs_t p1_r, p1_nxt, p2_r, p2_nxt;
  logic change_irq_master_enable_r, change_irq_master_enable_nxt;
  logic [1:0] evt_stat_r, evt_stat_nxt, evt_mask_r, evt_mask_nxt;
  logic [7:0] reg_rdata_nxt;
  logic change_irq_nxt, wake_req_nxt, evt_irq_nxt;
  logic change_irq_r, wake_req_r, evt_irq_r;
  logic [7:0] p1_hit, p2_hit;
  logic change_summary_flag;
  logic any_hit;
  logic sleep_s1_r, sleep_s2_r;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Edge detectors, one per port
  pec_edge_det #(.WIDTH(8), .PIN_MASK(PEC_P1_MASK)) u_det_p1 (
    .mclk(mclk),
    .reset(reset),
    .pin_in(first_gp_port),
    .rise_en(p1_r.rise),
    .fall_en(p1_r.fall),
    .edge_hit(p1_hit)
  );
  pec_edge_det #(.WIDTH(8), .PIN_MASK(PEC_P2_MASK)) u_det_p2 (
    .mclk(mclk),
    .reset(reset),
    .pin_in(second_gp_port),
    .rise_en(p2_r.rise),
    .fall_en(p2_r.fall),
    .edge_hit(p2_hit)
  );

  assign change_summary_flag = |{p1_r.flag, p2_r.flag};
  assign any_hit = |{p1_hit, p2_hit};

  // Register state next values
  always_comb begin
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    change_irq_master_enable_nxt = change_irq_master_enable_r;
    evt_mask_nxt = evt_mask_r;
    evt_stat_nxt = evt_stat_r;
    if (bus.wr) begin
      unique case (bus.addr)
        PEC_OFF_P1_RISE: p1_nxt.rise = bus.wdata & PEC_P1_MASK;
        PEC_OFF_P1_FALL: p1_nxt.fall = bus.wdata & PEC_P1_MASK;
        PEC_OFF_P1_FLAG: p1_nxt.flag = p1_r.flag & bus.wdata;
        PEC_OFF_P2_RISE: p2_nxt.rise = bus.wdata & PEC_P2_MASK;
        PEC_OFF_P2_FALL: p2_nxt.fall = bus.wdata & PEC_P2_MASK;
        PEC_OFF_P2_FLAG: p2_nxt.flag = p2_r.flag & bus.wdata;
        PEC_OFF_CTRL: change_irq_master_enable_nxt = bus.wdata[PEC_CTRL_MIE_BIT];
        PEC_OFF_EVT_STAT: evt_stat_nxt = evt_stat_r & ~bus.wdata[1:0];
        PEC_OFF_EVT_MASK: evt_mask_nxt = bus.wdata[1:0];
        default: ;
      endcase
    end
    // Hardware set wins over a clearing write in the same cycle
    p1_nxt.flag = (p1_nxt.flag | p1_hit) & PEC_P1_MASK;
    p2_nxt.flag = (p2_nxt.flag | p2_hit) & PEC_P2_MASK;
    if (any_hit) evt_stat_nxt[PEC_EVT_EDGE_BIT] = 1'b1;
    if (wake_req_nxt && !wake_req_r) evt_stat_nxt[PEC_EVT_WAKE_BIT] = 1'b1;
  end

  // Read data, one cycle after the strobe
  always_comb begin
    reg_rdata_nxt = PEC_RST_VAL;
    if (bus.rd) begin
      unique case (bus.addr)
        PEC_OFF_P1_RISE: reg_rdata_nxt = p1_r.rise;
        PEC_OFF_P1_FALL: reg_rdata_nxt = p1_r.fall;
        PEC_OFF_P1_FLAG: reg_rdata_nxt = p1_r.flag;
        PEC_OFF_P2_RISE: reg_rdata_nxt = p2_r.rise;
        PEC_OFF_P2_FALL: reg_rdata_nxt = p2_r.fall;
        PEC_OFF_P2_FLAG: reg_rdata_nxt = p2_r.flag;
        PEC_OFF_CTRL: begin
          reg_rdata_nxt[PEC_CTRL_MIE_BIT] = change_irq_master_enable_r;
          reg_rdata_nxt[PEC_CTRL_SUM_BIT] = change_summary_flag;
          reg_rdata_nxt[PEC_CTRL_SLEEP_BIT] = sleep_s2_r;
        end
        PEC_OFF_EVT_STAT: reg_rdata_nxt = {6'h00, evt_stat_r};
        PEC_OFF_EVT_MASK: reg_rdata_nxt = {6'h00, evt_mask_r};
        default: reg_rdata_nxt = PEC_RST_VAL;
      endcase
    end
  end

  // Request outputs; request changes in the same cycle as the flags
  always_comb begin
    change_irq_nxt = change_irq_master_enable_nxt
                   & (|{p1_nxt.flag, p2_nxt.flag});
    // Wake only from sleep and only when the master enable allows a request
    wake_req_nxt = sleep_s2_r & change_irq_nxt;
    evt_irq_nxt = |(evt_stat_nxt & evt_mask_nxt);
  end

  // Sleep level comes from the core power domain, so synchronise it
  always_ff @(posedge mclk) begin
    if (reset) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      sleep_s1_r <= core_sleep;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      p1_r <= '0;
      p2_r <= '0;
      change_irq_master_enable_r <= 1'b0;
      evt_stat_r <= 2'h0;
      evt_mask_r <= 2'h0;
      reg_rdata <= PEC_RST_VAL;
      change_irq_r <= 1'b0;
      wake_req_r <= 1'b0;
      evt_irq_r <= 1'b0;
    end else begin
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      change_irq_master_enable_r <= change_irq_master_enable_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_mask_r <= evt_mask_nxt;
      reg_rdata <= reg_rdata_nxt;
      change_irq_r <= change_irq_nxt;
      wake_req_r <= wake_req_nxt;
      evt_irq_r <= evt_irq_nxt;
    end
  end

  assign change_irq = change_irq_r;
  assign wake_req = wake_req_r;
  assign evt_irq = evt_irq_r;

  // Checks
  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (reset)
    p1_hit[0] |=> p1_r.flag[0]) else $error("edge did not set flag");
  AST_SET_WINS: assert property (@(posedge mclk) disable iff (reset)
    (bus.wr && bus.addr == PEC_OFF_P2_FLAG && p2_hit[4]) |=> p2_r.flag[4])
    else $error("clear beat a concurrent edge");
  AST_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    (bus.wr && bus.addr == PEC_OFF_P1_FLAG && !bus.wdata[1] && !p1_hit[1]) |=> !p1_r.flag[1])
    else $error("write zero did not clear flag");
  AST_P1_UPPER: assert property (@(posedge mclk) disable iff (reset)
    p1_r.rise[7:6] == 2'b00 && p1_r.flag[7:6] == 2'b00) else $error("port one upper bits set");
  AST_P2_LOWER: assert property (@(posedge mclk) disable iff (reset)
    p2_r.fall[3:0] == 4'h0 && p2_r.flag[3:0] == 4'h0) else $error("port two lower bits set");
  AST_IRQ: assert property (@(posedge mclk) disable iff (reset)
    change_irq_r == $past(change_irq_master_enable_r && change_summary_flag, 1) || $past(bus.wr)
    || $past(any_hit)) else $error("request does not follow flags");
  AST_NO_IRQ_OFF: assert property (@(posedge mclk) disable iff (reset)
    !change_irq_master_enable_r |-> !change_irq_r || $past(change_irq_master_enable_r))
    else $error("request with master enable off");
  AST_WAKE: assert property (@(posedge mclk) disable iff (reset)
    (sleep_s2_r && change_irq_master_enable_r && any_hit && !bus.wr) |=> wake_req_r ##0 change_summary_flag)
    else $error("no wake on edge in sleep");
  AST_RISE_GATE: assert property (@(posedge mclk) disable iff (reset)
    (!p1_r.rise[2] && !p1_r.fall[2]) |-> !p1_hit[2]) else $error("disabled pin detected");

  // Bus steps that the checks below start from
  sequence s_p1_flag_wr;
    bus.wr && bus.addr == PEC_OFF_P1_FLAG;
  endsequence
  sequence s_p2_flag_wr;
    bus.wr && bus.addr == PEC_OFF_P2_FLAG;
  endsequence
  sequence s_p1_flag_idle;
    !(bus.wr && bus.addr == PEC_OFF_P1_FLAG);
  endsequence
  sequence s_p2_flag_idle;
    !(bus.wr && bus.addr == PEC_OFF_P2_FLAG);
  endsequence
  sequence s_p1_rise_wr;
    bus.wr && bus.addr == PEC_OFF_P1_RISE;
  endsequence
  sequence s_p2_fall_wr;
    bus.wr && bus.addr == PEC_OFF_P2_FALL;
  endsequence
  sequence s_ctrl_rd;
    bus.rd && bus.addr == PEC_OFF_CTRL;
  endsequence
  sequence s_p1_flag_rd;
    bus.rd && bus.addr == PEC_OFF_P1_FLAG;
  endsequence

  // change_irq and evt_irq are pure functions of registered state; wake_req uses the previous cycle's sleep_s2_r
  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (reset)
    change_irq_r == (change_irq_master_enable_r && change_summary_flag))
    else $error("request level differs from enable and flags");
  AST_WAKE_LEVEL: assert property (@(posedge mclk) disable iff (reset)
    wake_req_r |-> change_irq_r && sleep_s2_r)
    else $error("wake without request in sleep");
  AST_WAKE_NEEDS_MIE: assert property (@(posedge mclk) disable iff (reset)
    !change_irq_master_enable_r |-> !wake_req_r)
    else $error("wake with master enable off");
  AST_WAKE_FLAGS: assert property (@(posedge mclk) disable iff (reset)
    (wake_req_r && !$past(wake_req_r)) |-> change_summary_flag)
    else $error("wake before flags updated");
  AST_EVT_LEVEL: assert property (@(posedge mclk) disable iff (reset)
    evt_irq_r == |(evt_stat_r & evt_mask_r))
    else $error("event request differs from status and mask");

  // Flags are sticky: without a clearing write no set bit drops
  AST_P1_STICKY: assert property (@(posedge mclk) disable iff (reset)
    s_p1_flag_idle |=> ((p1_r.flag & $past(p1_r.flag)) == $past(p1_r.flag)))
    else $error("port one flag dropped without a write");
  AST_P2_STICKY: assert property (@(posedge mclk) disable iff (reset)
    s_p2_flag_idle |=> ((p2_r.flag & $past(p2_r.flag)) == $past(p2_r.flag)))
    else $error("port two flag dropped without a write");

  // Clearing writes, and the edge that races them
  AST_P1_CLEAR_ALL: assert property (@(posedge mclk) disable iff (reset)
    s_p1_flag_wr ##0 (bus.wdata == 8'h00 && p1_hit == 8'h00) |=> p1_r.flag == 8'h00)
    else $error("port one flags not cleared");
  AST_P2_CLEAR_ALL: assert property (@(posedge mclk) disable iff (reset)
    s_p2_flag_wr ##0 (bus.wdata == 8'h00 && p2_hit == 8'h00) |=> p2_r.flag == 8'h00)
    else $error("port two flags not cleared");
  AST_P1_SET_WINS: assert property (@(posedge mclk) disable iff (reset)
    s_p1_flag_wr ##0 (p1_hit != 8'h00) |=> ((p1_r.flag & $past(p1_hit)) == $past(p1_hit)))
    else $error("port one clear beat an edge");
  AST_P2_SET_WINS: assert property (@(posedge mclk) disable iff (reset)
    s_p2_flag_wr ##0 (p2_hit != 8'h00) |=> ((p2_r.flag & $past(p2_hit)) == $past(p2_hit)))
    else $error("port two clear beat an edge");

  // Enables gate detection, and only implemented pins hold bits
  AST_P2_GATE: assert property (@(posedge mclk) disable iff (reset)
    (p2_r.rise == 8'h00 && p2_r.fall == 8'h00) |-> p2_hit == 8'h00)
    else $error("port two detected with enables off");
  AST_P1_FALL_UPPER: assert property (@(posedge mclk) disable iff (reset)
    p1_r.fall[7:6] == 2'b00)
    else $error("port one fall enable upper bits set");
  AST_P2_RISE_LOWER: assert property (@(posedge mclk) disable iff (reset)
    p2_r.rise[3:0] == 4'h0)
    else $error("port two rise enable lower bits set");
  AST_P1_RISE_WR: assert property (@(posedge mclk) disable iff (reset)
    s_p1_rise_wr |=> p1_r.rise == ($past(bus.wdata) & PEC_P1_MASK))
    else $error("port one rise enable write wrong");
  AST_P2_FALL_WR: assert property (@(posedge mclk) disable iff (reset)
    s_p2_fall_wr |=> p2_r.fall == ($past(bus.wdata) & PEC_P2_MASK))
    else $error("port two fall enable write wrong");

  // Read data stand one cycle after the strobe, zero otherwise
  AST_SUM_RD: assert property (@(posedge mclk) disable iff (reset)
    s_ctrl_rd |=> reg_rdata[PEC_CTRL_SUM_BIT] == $past(change_summary_flag))
    else $error("summary flag read wrong");
  AST_FLAG_RD: assert property (@(posedge mclk) disable iff (reset)
    s_p1_flag_rd |=> reg_rdata == $past(p1_r.flag))
    else $error("port one flag read wrong");
  AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (reset)
    !bus.rd |=> reg_rdata == PEC_RST_VAL)
    else $error("read data without a read strobe");
endmodule

// ---- verif/pec_pin_model.sv ----
// Model of the external signals driven onto the two port pins
`timescale 1ns/10ps
module pec_pin_model (
  // Clock
  input wire logic mclk,
  // Levels asked for by the bench
  input wire logic [7:0] p1_set,
  input wire logic [7:0] p2_set,
  // Pin levels
  output logic [7:0] first_gp_port,
  output logic [7:0] second_gp_port
);
  // Pins idle low before the first clock
  initial begin
    first_gp_port = 8'h00;
    second_gp_port = 8'h00;
  end
  // Pins move 2 ns after each clock edge, a fixed offset from the edge the unit samples on
  always @(posedge mclk) begin
    first_gp_port <= #2 p1_set;
    second_gp_port <= #2 p2_set;
  end
endmodule

// ---- verif/pin_edge_change_interrupt_tb.sv ----
// Self-checking bench for the pin edge-change interrupt unit
`timescale 1ns/10ps
module pin_edge_change_interrupt_tb import pec_pkg::*;;
  logic mclk, reset, reg_wr, reg_rd, core_sleep, change_irq, wake_req, evt_irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, p1_set, p2_set, first_gp_port, second_gp_port, rd_val;
  int num_errors = 0;
  int samples_checked = 0;
  pec_top DUT (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_gp_port(first_gp_port),
    .second_gp_port(second_gp_port), .core_sleep(core_sleep), .change_irq(change_irq),
    .wake_req(wake_req), .evt_irq(evt_irq));
  pec_pin_model pins (.mclk(mclk), .p1_set(p1_set), .p2_set(p2_set),
    .first_gp_port(first_gp_port), .second_gp_port(second_gp_port));
  // Core clock, 8 ns
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    chk(rd_val, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // Drive pins, then let the edge clear the synchroniser
  task automatic pins_to(input logic [7:0] a, input logic [7:0] b);
    @(posedge mclk);
    p1_set <= a;
    p2_set <= b;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  // Reset values and an unmapped read
  task automatic t_reset;
    for (int a = 0; a < 9; a++) rdc(a[3:0], PEC_RST_VAL);
    rdc(4'hF, 8'h00);
    chk({7'h00, change_irq}, 8'h00);
  endtask
  // Pin masks, unmapped write, then the enable pattern used below
  task automatic t_mask;
    wr(PEC_OFF_P1_RISE, 8'hFF);
    rdc(PEC_OFF_P1_RISE, PEC_P1_MASK);
    wr(PEC_OFF_P2_FALL, 8'hFF);
    rdc(PEC_OFF_P2_FALL, PEC_P2_MASK);
    wr(4'hF, 8'hFF);
    rdc(4'hF, 8'h00);
    wr(PEC_OFF_P1_RISE, 8'h05);
    wr(PEC_OFF_P1_FALL, 8'h06);
    wr(PEC_OFF_P2_RISE, 8'h10);
    wr(PEC_OFF_P2_FALL, 8'h20);
  endtask
  // Edges of each polarity with the master enable off
  task automatic t_edges;
    pins_to(8'hFF, 8'hFF);
    rdc(PEC_OFF_P1_FLAG, 8'h05);
    rdc(PEC_OFF_P2_FLAG, 8'h10);
    chk({7'h00, change_irq}, 8'h00);
    rdc(PEC_OFF_CTRL, 8'h02);
    wr(PEC_OFF_P1_FLAG, 8'h00);
    wr(PEC_OFF_P2_FLAG, 8'h00);
    rdc(PEC_OFF_P1_FLAG, 8'h00);
    rdc(PEC_OFF_CTRL, 8'h00);
    pins_to(8'h00, 8'h00);
    rdc(PEC_OFF_P1_FLAG, 8'h06);
    rdc(PEC_OFF_P2_FLAG, 8'h20);
  endtask
  // Master enable, masked clear, an edge racing a clear
  task automatic t_irq;
    wr(PEC_OFF_CTRL, 8'h01);
    settle;
    chk({7'h00, change_irq}, 8'h01);
    rd(PEC_OFF_P1_FLAG);
    wr(PEC_OFF_P1_FLAG, ~rd_val);
    wr(PEC_OFF_P2_FLAG, 8'hDF);
    settle;
    chk({7'h00, change_irq}, 8'h00);
    @(posedge mclk);
    p1_set <= 8'h01;
    repeat (2) @(posedge mclk);
    wr(PEC_OFF_P1_FLAG, 8'hFE);
    settle;
    rdc(PEC_OFF_P1_FLAG, 8'h01);
    chk({7'h00, change_irq}, 8'h01);
    wr(PEC_OFF_P1_FLAG, 8'h00);
  endtask
  // Wake from sleep, then the event interrupt
  task automatic t_sleep;
    @(posedge mclk);
    core_sleep <= 1'b1;
    pins_to(8'h05, 8'h00);
    chk({7'h00, wake_req}, 8'h01);
    rdc(PEC_OFF_P1_FLAG, 8'h04);
    rdc(PEC_OFF_CTRL, 8'h07);
    wr(PEC_OFF_CTRL, 8'h00);
    settle;
    chk({6'h00, wake_req, change_irq}, 8'h00);
    rdc(PEC_OFF_EVT_STAT, 8'h03);
    chk({7'h00, evt_irq}, 8'h00);
    wr(PEC_OFF_EVT_MASK, 8'h01);
    settle;
    chk({7'h00, evt_irq}, 8'h01);
    wr(PEC_OFF_EVT_STAT, 8'h01);
    settle;
    chk({7'h00, evt_irq}, 8'h00);
    rdc(PEC_OFF_EVT_STAT, 8'h02);
  endtask
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    core_sleep = 1'b0;
    p1_set = 8'h00;
    p2_set = 8'h00;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_mask;
    t_edges;
    t_irq;
    t_sleep;
    end_of_test;
  end
  // Watchdog, well beyond the 150 or so cycles the tests need
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule
